// ===== rtl/frt_map.svh
// register offsets, field positions and reset values of the capture/compare timer
`ifndef FRT_MAP_SVH
`define FRT_MAP_SVH

// ****************************************************************
// register offsets on the 8-bit peripheral port
// ****************************************************************
`define FRT_ADDR_CNT_HI 4'h0
`define FRT_ADDR_CNT_LO 4'h1
`define FRT_ADDR_CMP_HI 4'h2
`define FRT_ADDR_CMP_LO 4'h3
`define FRT_ADDR_CAPA_HI 4'h4
`define FRT_ADDR_CAPA_LO 4'h5
`define FRT_ADDR_CAPB_HI 4'h6
`define FRT_ADDR_CAPB_LO 4'h7
`define FRT_ADDR_CAPC_HI 4'h8
`define FRT_ADDR_CAPC_LO 4'h9
`define FRT_ADDR_CAPD_HI 4'ha
`define FRT_ADDR_CAPD_LO 4'hb
`define FRT_ADDR_IRQ_EN 4'hc
`define FRT_ADDR_STATUS 4'hd
`define FRT_ADDR_CAP_CLK 4'he
`define FRT_ADDR_CMP_OUT 4'hf

// ****************************************************************
// field positions
// ****************************************************************
`define FRT_CC_EDGE_A 7
`define FRT_CC_EDGE_B 6
`define FRT_CC_EDGE_C 5
`define FRT_CC_EDGE_D 4
`define FRT_CC_BUF_A 3
`define FRT_CC_BUF_B 2
`define FRT_OC_SEL 4
`define FRT_OC_OE_A 3
`define FRT_OC_OE_B 2
`define FRT_OC_LVL_A 1
`define FRT_OC_LVL_B 0
`define FRT_ST_CLR_A 0

// ****************************************************************
// reset values and fixed bits
// ****************************************************************
`define FRT_CAP_CLK_RST 8'h00
`define FRT_CMP_OUT_RST 8'he0
`define FRT_CMP_OUT_FIXED 8'he0
`define FRT_IRQ_EN_RST 8'h01
`define FRT_IRQ_EN_FIXED 8'h01
`define FRT_STATUS_RST 8'h00
`define FRT_CNT_RST 16'h0000
`define FRT_CMP_RST 16'hffff
`define FRT_CAP_RST 16'h0000
`define FRT_CNT_MAX 16'hffff

// ****************************************************************
// prescaler tap positions for the internal count clocks
// ****************************************************************
`define FRT_PRE_W 5
`define FRT_TAP_DIV2 0
`define FRT_TAP_DIV8 2
`define FRT_TAP_DIV32 4

`endif

// ===== rtl/frt_pkg.sv
// types shared by the capture/compare timer files
package frt_pkg;
  // ****************************************************************
  // count clock selection
  // ****************************************************************
  typedef enum logic [1:0] {
    FRT_CLK_DIV2,
    FRT_CLK_DIV8,
    FRT_CLK_DIV32,
    FRT_CLK_EXT
  } frt_clk_e;
  typedef logic [7:0] frt_byte_t; // one bus byte
  typedef logic [15:0] frt_word_t; // one timer word
endpackage

// ===== rtl/frt_edge_det.sv
// synchroniser and selectable edge detector for one timer input pin
`timescale 1ns/10ps
module frt_edge_det (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic pin_in,
  input wire logic rise_sel,
  output logic edge_pulse
);
  logic sync1_q; // first stage, read only by second stage
  logic sync2_q; // settled sample
  logic prev_q; // previous settled sample

  // ****************************************************************
  // two-flop synchroniser and history
  // ****************************************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // rising when selected, falling otherwise
  always_comb begin
    if (rise_sel) begin
      edge_pulse = sync2_q & ~prev_q;
    end else begin
      edge_pulse = ~sync2_q & prev_q;
    end
  end
endmodule

// ===== rtl/frt_timer.sv
// free-running 16-bit timer with two compare and four capture channels
//
// Behaviour
// - compare match A clears counter when enabled
// - per-pin capture edge: 0 falling, 1 rising
// - buffer_en_a makes capture C buffer A
// - buffer_en_b makes capture D buffer B
// - clk_sel picks div2, div8, div32, external
// - capture/clock control zero on reset, low-power
// - compare output control E0 on reset, low-power
// - output control bits 7..5 read one
// - select bit routes shared compare address
// - output enable bits gate compare pins
// - level bits choose pin level on match
// - upper write latches; lower write loads word
// - counter/capture upper read latches lower byte
// - compare reads bypass the staging latch
// - counter starts zero, counts selected ticks
// - continuous compare drives pin to level
// - compare pins low until first match
// - capture edge loads counter, sets flag
// - buffered capture shifts old value, loads
// - hardware sets flags; read-one-write-zero clears
// - buffered C/D edge flags only, no load
`timescale 1ns/10ps
module frt_timer (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic low_power,
  input wire logic [3:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire frt_pkg::frt_byte_t bus_wdata,
  output frt_pkg::frt_byte_t bus_rdata,
  input wire logic capture_in_a,
  input wire logic capture_in_b,
  input wire logic capture_in_c,
  input wire logic capture_in_d,
  input wire logic ext_count_clk,
  output logic compare_out_a,
  output logic compare_out_b,
  output logic compare_out_oe_a,
  output logic compare_out_oe_b,
  output logic irq
);
  import frt_pkg::*;
  `include "frt_map.svh"

  // ****************************************************************
  // storage
  // ****************************************************************
  frt_word_t free_run_counter_q; // the counter
  frt_word_t compare_reg_a_q; // compare word A
  frt_word_t compare_reg_b_q; // compare word B
  frt_word_t capture_q [4]; // capture words A..D
  frt_byte_t byte_staging_latch_q; // shared byte staging latch
  frt_byte_t cap_clk_ctrl_q; // edge, buffer and clock select
  frt_byte_t cmp_out_ctrl_q; // select, enables, levels (low five bits used)
  frt_byte_t irq_enable_reg_q; // per-flag interrupt enables
  frt_byte_t status_q; // flags 7..1, clear_on_match_a at 0
  frt_byte_t armed_q; // flags seen as one by software
  logic [3:0] cap_pend_q; // captures delayed by an upper-byte read
  logic [`FRT_PRE_W-1:0] pre_q; // system clock prescaler
  logic tap_q; // previous selected prescaler tap
  frt_byte_t rdata_q; // read answer
  logic out_a_q; // compare pin A level
  logic out_b_q; // compare pin B level
  logic irq_q; // registered interrupt request

  // ****************************************************************
  // decode and derived controls
  // ****************************************************************
  frt_clk_e clk_sel; // counter clock source
  logic buf_a; // capture C buffers A
  logic buf_b; // capture D buffers B
  logic sel_b; // compare address routes to B
  logic wr_cnt_lo; // lower counter write
  logic wr_cmp_lo; // lower compare write
  logic [3:0] cap_edge; // selected edges from pins
  logic ext_rise; // external clock rising edge
  logic tap_now; // current selected prescaler tap
  logic tick; // counter clock enable
  logic match_a; // compare match A event
  logic match_b; // compare match B event
  logic ovf; // overflow event
  logic [3:0] cap_busy; // upper byte of a receiving register being read
  logic [3:0] cap_go; // capture fires this cycle
  frt_byte_t flag_set; // hardware flag set events
  frt_byte_t rd_mux; // read data before register

  assign clk_sel = frt_clk_e'(cap_clk_ctrl_q[1:0]);
  assign buf_a = cap_clk_ctrl_q[`FRT_CC_BUF_A];
  assign buf_b = cap_clk_ctrl_q[`FRT_CC_BUF_B];
  assign sel_b = cmp_out_ctrl_q[`FRT_OC_SEL];
  assign wr_cnt_lo = bus_wr && (bus_addr == `FRT_ADDR_CNT_LO);
  assign wr_cmp_lo = bus_wr && (bus_addr == `FRT_ADDR_CMP_LO);

  // ****************************************************************
  // pin synchronisers and edge detectors
  // ****************************************************************
  // capture pins, edge chosen per channel
  frt_edge_det u_edge_a (.core_clk(core_clk), .arst_n(arst_n), .pin_in(capture_in_a),
    .rise_sel(cap_clk_ctrl_q[`FRT_CC_EDGE_A]), .edge_pulse(cap_edge[0]));
  frt_edge_det u_edge_b (.core_clk(core_clk), .arst_n(arst_n), .pin_in(capture_in_b),
    .rise_sel(cap_clk_ctrl_q[`FRT_CC_EDGE_B]), .edge_pulse(cap_edge[1]));
  frt_edge_det u_edge_c (.core_clk(core_clk), .arst_n(arst_n), .pin_in(capture_in_c),
    .rise_sel(cap_clk_ctrl_q[`FRT_CC_EDGE_C]), .edge_pulse(cap_edge[2]));
  frt_edge_det u_edge_d (.core_clk(core_clk), .arst_n(arst_n), .pin_in(capture_in_d),
    .rise_sel(cap_clk_ctrl_q[`FRT_CC_EDGE_D]), .edge_pulse(cap_edge[3]));
  // external count clock, rising edge only
  frt_edge_det u_edge_ext (.core_clk(core_clk), .arst_n(arst_n), .pin_in(ext_count_clk),
    .rise_sel(1'b1), .edge_pulse(ext_rise));

  // ****************************************************************
  // count clock selection
  // ****************************************************************
  // internal ticks come from the falling edge of the chosen divided clock
  always_comb begin
    case (clk_sel)
      FRT_CLK_DIV2: tap_now = pre_q[`FRT_TAP_DIV2];
      FRT_CLK_DIV8: tap_now = pre_q[`FRT_TAP_DIV8];
      FRT_CLK_DIV32: tap_now = pre_q[`FRT_TAP_DIV32];
      default: tap_now = 1'b0;
    endcase
    if (clk_sel == FRT_CLK_EXT) begin
      tick = ext_rise;
    end else begin
      tick = tap_q & ~tap_now;
    end
  end

  // prescaler and tap history, held in reset during low power
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_q <= '0;
      tap_q <= 1'b0;
    end else if (low_power) begin
      pre_q <= '0;
      tap_q <= 1'b0;
    end else begin
      pre_q <= pre_q + 1'b1;
      tap_q <= tap_now;
    end
  end

  // ****************************************************************
  // compare, overflow and capture events
  // ****************************************************************
  // a match fires as the counter leaves the matching value;
  // a lower-byte write to that compare word suppresses it
  always_comb begin
    match_a = tick && (free_run_counter_q == compare_reg_a_q) && !(wr_cmp_lo && !sel_b);
    match_b = tick && (free_run_counter_q == compare_reg_b_q) && !(wr_cmp_lo && sel_b);
    ovf = tick && (free_run_counter_q == `FRT_CNT_MAX) && !(match_a && status_q[`FRT_ST_CLR_A]);
  end

  // an upper-byte read of a receiving register delays capture one clock
  always_comb begin
    cap_busy[0] = bus_rd && ((bus_addr == `FRT_ADDR_CAPA_HI) || (buf_a && bus_addr == `FRT_ADDR_CAPC_HI));
    cap_busy[1] = bus_rd && ((bus_addr == `FRT_ADDR_CAPB_HI) || (buf_b && bus_addr == `FRT_ADDR_CAPD_HI));
    cap_busy[2] = bus_rd && !buf_a && (bus_addr == `FRT_ADDR_CAPC_HI);
    cap_busy[3] = bus_rd && !buf_b && (bus_addr == `FRT_ADDR_CAPD_HI);
    cap_go = (cap_edge | cap_pend_q) & ~cap_busy;
  end

  // pending captures
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_pend_q <= '0;
    end else if (low_power) begin
      cap_pend_q <= '0;
    end else begin
      cap_pend_q <= (cap_edge | cap_pend_q) & cap_busy;
    end
  end

  // ****************************************************************
  // free-running counter
  // ****************************************************************
  // clear beats a write, a write beats an increment
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      free_run_counter_q <= `FRT_CNT_RST;
    end else if (low_power) begin
      free_run_counter_q <= `FRT_CNT_RST;
    end else if (match_a && status_q[`FRT_ST_CLR_A]) begin
      free_run_counter_q <= `FRT_CNT_RST;
    end else if (wr_cnt_lo) begin
      free_run_counter_q <= {byte_staging_latch_q, bus_wdata};
    end else if (tick) begin
      free_run_counter_q <= free_run_counter_q + 16'h0001;
    end
  end

  // ****************************************************************
  // compare words, shared address
  // ****************************************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      compare_reg_a_q <= `FRT_CMP_RST;
      compare_reg_b_q <= `FRT_CMP_RST;
    end else if (low_power) begin
      compare_reg_a_q <= `FRT_CMP_RST;
      compare_reg_b_q <= `FRT_CMP_RST;
    end else if (wr_cmp_lo) begin
      // select bit only routes the access
      if (sel_b) begin
        compare_reg_b_q <= {byte_staging_latch_q, bus_wdata};
      end else begin
        compare_reg_a_q <= {byte_staging_latch_q, bus_wdata};
      end
    end
  end

  // ****************************************************************
  // capture words
  // ****************************************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        capture_q[i] <= `FRT_CAP_RST;
      end
    end else if (low_power) begin
      for (int i = 0; i < 4; i++) begin
        capture_q[i] <= `FRT_CAP_RST;
      end
    end else begin
      // channels A and B always load the counter
      if (cap_go[0]) begin
        capture_q[0] <= free_run_counter_q;
      end
      if (cap_go[1]) begin
        capture_q[1] <= free_run_counter_q;
      end
      // channel C: buffer of A, or its own capture
      if (buf_a) begin
        if (cap_go[0]) begin
          capture_q[2] <= capture_q[0];
        end
      end else if (cap_go[2]) begin
        capture_q[2] <= free_run_counter_q;
      end
      // channel D: buffer of B, or its own capture
      if (buf_b) begin
        if (cap_go[1]) begin
          capture_q[3] <= capture_q[1];
        end
      end else if (cap_go[3]) begin
        capture_q[3] <= free_run_counter_q;
      end
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_clk_ctrl_q <= `FRT_CAP_CLK_RST;
      cmp_out_ctrl_q <= `FRT_CMP_OUT_RST;
      irq_enable_reg_q <= `FRT_IRQ_EN_RST;
    end else if (low_power) begin
      cap_clk_ctrl_q <= `FRT_CAP_CLK_RST;
      cmp_out_ctrl_q <= `FRT_CMP_OUT_RST;
      irq_enable_reg_q <= `FRT_IRQ_EN_RST;
    end else if (bus_wr) begin
      case (bus_addr)
        `FRT_ADDR_CAP_CLK: cap_clk_ctrl_q <= bus_wdata;
        `FRT_ADDR_CMP_OUT: cmp_out_ctrl_q <= bus_wdata | `FRT_CMP_OUT_FIXED;
        `FRT_ADDR_IRQ_EN: irq_enable_reg_q <= bus_wdata | `FRT_IRQ_EN_FIXED;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // status flags and clear-on-match bit
  // ****************************************************************
  assign flag_set = {cap_go[0], cap_go[1], cap_go[2], cap_go[3], match_a, match_b, ovf, 1'b0};

  // a flag clears only if it was read as one; a set in the same cycle wins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= `FRT_STATUS_RST;
      armed_q <= '0;
    end else if (low_power) begin
      status_q <= `FRT_STATUS_RST;
      armed_q <= '0;
    end else begin
      if (bus_wr && bus_addr == `FRT_ADDR_STATUS) begin
        status_q[7:1] <= (status_q[7:1] & ~(armed_q[7:1] & ~bus_wdata[7:1])) | flag_set[7:1];
        status_q[`FRT_ST_CLR_A] <= bus_wdata[`FRT_ST_CLR_A];
        armed_q <= '0;
      end else begin
        status_q[7:1] <= status_q[7:1] | flag_set[7:1];
      end
      if (bus_rd && bus_addr == `FRT_ADDR_STATUS) begin
        armed_q <= status_q;
      end
    end
  end

  // ****************************************************************
  // staging latch
  // ****************************************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      byte_staging_latch_q <= '0;
    end else if (bus_wr && (bus_addr == `FRT_ADDR_CNT_HI || bus_addr == `FRT_ADDR_CMP_HI)) begin
      byte_staging_latch_q <= bus_wdata;
    end else if (bus_rd) begin
      // upper reads of counter/capture keep the lower byte
      case (bus_addr)
        `FRT_ADDR_CNT_HI: byte_staging_latch_q <= free_run_counter_q[7:0];
        `FRT_ADDR_CAPA_HI: byte_staging_latch_q <= capture_q[0][7:0];
        `FRT_ADDR_CAPB_HI: byte_staging_latch_q <= capture_q[1][7:0];
        `FRT_ADDR_CAPC_HI: byte_staging_latch_q <= capture_q[2][7:0];
        `FRT_ADDR_CAPD_HI: byte_staging_latch_q <= capture_q[3][7:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  always_comb begin
    case (bus_addr)
      `FRT_ADDR_CNT_HI: rd_mux = free_run_counter_q[15:8];
      `FRT_ADDR_CAPA_HI: rd_mux = capture_q[0][15:8];
      `FRT_ADDR_CAPB_HI: rd_mux = capture_q[1][15:8];
      `FRT_ADDR_CAPC_HI: rd_mux = capture_q[2][15:8];
      `FRT_ADDR_CAPD_HI: rd_mux = capture_q[3][15:8];
      // lower bytes of counter and captures come from the latch
      `FRT_ADDR_CNT_LO, `FRT_ADDR_CAPA_LO, `FRT_ADDR_CAPB_LO,
      `FRT_ADDR_CAPC_LO, `FRT_ADDR_CAPD_LO: rd_mux = byte_staging_latch_q;
      // compare bytes read straight
      `FRT_ADDR_CMP_HI: rd_mux = sel_b ? compare_reg_b_q[15:8] : compare_reg_a_q[15:8];
      `FRT_ADDR_CMP_LO: rd_mux = sel_b ? compare_reg_b_q[7:0] : compare_reg_a_q[7:0];
      `FRT_ADDR_IRQ_EN: rd_mux = irq_enable_reg_q;
      `FRT_ADDR_STATUS: rd_mux = status_q;
      `FRT_ADDR_CAP_CLK: rd_mux = cap_clk_ctrl_q;
      `FRT_ADDR_CMP_OUT: rd_mux = cmp_out_ctrl_q | `FRT_CMP_OUT_FIXED;
      default: rd_mux = '0;
    endcase
  end

  // read data registered, held between reads
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else if (bus_rd) begin
      rdata_q <= rd_mux;
    end
  end

  // ****************************************************************
  // compare pins and interrupt
  // ****************************************************************
  // pins low until their first match, then take the level bit
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end else if (low_power) begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end else begin
      if (match_a) begin
        out_a_q <= cmp_out_ctrl_q[`FRT_OC_LVL_A];
      end
      if (match_b) begin
        out_b_q <= cmp_out_ctrl_q[`FRT_OC_LVL_B];
      end
    end
  end

  // one request for any enabled flag
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q[7:1] & irq_enable_reg_q[7:1]);
    end
  end

  assign bus_rdata = rdata_q;
  assign compare_out_a = out_a_q;
  assign compare_out_b = out_b_q;
  assign compare_out_oe_a = cmp_out_ctrl_q[`FRT_OC_OE_A];
  assign compare_out_oe_b = cmp_out_ctrl_q[`FRT_OC_OE_B];
  assign irq = irq_q;
endmodule

// ===== test/frt_pins.sv
// pin-side model: capture pins and external count clock
`timescale 1ns/10ps
module frt_pins (
  input wire logic core_clk,
  input wire logic [4:0] want,
  output logic [3:0] cap_pin,
  output logic ext_pin
);
  // ****************************************************************
  // pins follow the requested levels one clock later, like a board flop
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    cap_pin <= want[3:0]; // chosen edges appear here
    ext_pin <= want[4]; // each phase held at least three clocks
  end
endmodule

// ===== test/frt_monitor.sv
// port checker for the capture/compare timer
`timescale 1ns/10ps
module frt_monitor (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic low_power,
  input wire logic [3:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire frt_pkg::frt_byte_t bus_wdata,
  input wire frt_pkg::frt_byte_t bus_rdata,
  input wire logic compare_out_a,
  input wire logic compare_out_b,
  input wire logic compare_out_oe_a
);
  import frt_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ****************************************************************
  // register write steps
  // ****************************************************************
  sequence s_wr_oc;
    bus_wr && bus_addr == 4'hf && !low_power;
  endsequence
  sequence s_wr_cc;
    bus_wr && bus_addr == 4'he && !low_power;
  endsequence
  // ****************************************************************
  // properties
  // ****************************************************************
  property p_oe_a;
    s_wr_oc |=> compare_out_oe_a == $past(bus_wdata[3]);
  endproperty
  property p_oc_rb;
    s_wr_oc ##1 (bus_rd && bus_addr == 4'hf) |=> bus_rdata == ($past(bus_wdata, 2) | 8'he0);
  endproperty
  property p_cc_rb;
    s_wr_cc ##1 (bus_rd && bus_addr == 4'he) |=> bus_rdata == $past(bus_wdata, 2);
  endproperty
  property p_fixed;
    bus_rd && bus_addr == 4'hf |=> bus_rdata[7:5] == 3'b111;
  endproperty
  property p_lp_oe;
    low_power |=> !compare_out_oe_a;
  endproperty
  property p_lp_pins;
    low_power |=> !compare_out_a && !compare_out_b;
  endproperty
  property p_lp_cc;
    low_power ##1 (low_power && bus_rd && bus_addr == 4'he) |=> bus_rdata == 8'h00;
  endproperty
  property p_lp_oc;
    low_power ##1 (low_power && bus_rd && bus_addr == 4'hf) |=> bus_rdata == 8'he0;
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("output enable A not from write");
  a_oc_rb: assert property (p_oc_rb) else $error("output control readback wrong");
  a_cc_rb: assert property (p_cc_rb) else $error("capture control readback wrong");
  a_fixed: assert property (p_fixed) else $error("reserved bits not one");
  a_lp_oe: assert property (p_lp_oe) else $error("enable set in low power");
  a_lp_pins: assert property (p_lp_pins) else $error("compare pin high in low power");
  a_lp_cc: assert property (p_lp_cc) else $error("capture control not cleared");
  a_lp_oc: assert property (p_lp_oc) else $error("output control not preset");
endmodule
bind frt_timer frt_monitor mon_u (.core_clk, .arst_n, .low_power, .bus_addr, .bus_wr, .bus_rd,
  .bus_wdata, .bus_rdata, .compare_out_a, .compare_out_b, .compare_out_oe_a);

// ===== test/testbench.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/10ps
module testbench;
  import frt_pkg::*;
  logic core_clk = 1'b0, arst_n = 1'b0, low_power = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
  logic [3:0] bus_addr = 4'h0;
  frt_byte_t bus_wdata = 8'h00, bus_rdata;
  logic [4:0] want = 5'h00; // requested pin levels: capture a..d, external clock
  logic [3:0] cap_pin;
  logic ext_pin, oa, ob, compare_out_en_a, compare_out_en_b, irq;
  int error_cnt = 0, n_tests = 0;
  frt_word_t w, w0;
  frt_byte_t hb;
  always #10 core_clk = ~core_clk;
  frt_pins pins_u (.core_clk(core_clk), .want(want), .cap_pin(cap_pin), .ext_pin(ext_pin));
  frt_timer dut_u (.core_clk(core_clk), .arst_n(arst_n), .low_power(low_power), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .capture_in_a(cap_pin[0]),
    .capture_in_b(cap_pin[1]), .capture_in_c(cap_pin[2]), .capture_in_d(cap_pin[3]), .ext_count_clk(ext_pin),
    .compare_out_a(oa), .compare_out_b(ob), .compare_out_oe_a(compare_out_en_a), .compare_out_oe_b(compare_out_en_b), .irq(irq));
  // ****************************************************************
  // bus access and comparison tasks
  // ****************************************************************
  task automatic chk(input string nm, input frt_word_t seen, input frt_word_t exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one byte transfer; strobe left up so transfers can run back to back
  task automatic op(input logic wr_en, input logic [3:0] a, input frt_byte_t d);
    bus_wr = wr_en;
    bus_rd = !wr_en;
    bus_addr = a;
    bus_wdata = d;
    @(posedge core_clk);
    #1;
  endtask
  task automatic idle();
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic wr8(input logic [3:0] a, input frt_byte_t d);
    op(1'b1, a, d);
    idle();
  endtask
  task automatic rd8(input logic [3:0] a, output frt_word_t v);
    op(1'b0, a, 8'h00);
    v = {8'h00, bus_rdata};
    idle();
  endtask
  task automatic wrrd(input string nm, input logic [3:0] a, input frt_byte_t d, input frt_byte_t e);
    op(1'b1, a, d);
    op(1'b0, a, 8'h00);
    idle();
    chk(nm, {8'h00, bus_rdata}, {8'h00, e});
  endtask
  // words go upper byte first, then lower
  task automatic wr16(input logic [3:0] a, input frt_word_t v);
    op(1'b1, a, v[15:8]);
    op(1'b1, a | 4'h1, v[7:0]);
    idle();
  endtask
  task automatic rd16(input logic [3:0] a, output frt_word_t v);
    op(1'b0, a, 8'h00);
    v[15:8] = bus_rdata;
    op(1'b0, a | 4'h1, 8'h00);
    v[7:0] = bus_rdata;
    idle();
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic pin(input int i, input logic v);
    want[i] = v;
    wait_clk(8);
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ****************************************************************
  // watchdog: the tests need about 1100 clocks
  // ****************************************************************
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    wait_clk(12);
    arst_n = 1'b1;
    rd8(4'he, w);
    chk("cap_clk_ctrl_rst", w, 16'h0000);
    rd8(4'hf, w);
    chk("cmp_out_ctrl_rst", w, 16'h00e0);
    chk("pins_rst", 16'({oa, ob, compare_out_en_a, compare_out_en_b}), 16'h0000);
    wrrd("cmp_out_ctrl_all", 4'hf, 8'h1f, 8'hff);
    wrrd("cmp_out_ctrl_none", 4'hf, 8'h00, 8'he0);
    // each internal rate over 256 clocks; lower byte read late must give the latched value
    for (int m = 0; m < 3; m++) begin
      wrrd("clk_mode", 4'he, 8'(m), 8'(m));
      rd16(4'h0, w0);
      wait_clk(253);
      op(1'b0, 4'h0, 8'h00);
      hb = bus_rdata;
      idle();
      wait_clk(20);
      rd8(4'h1, w);
      chk("tick_rate", {hb, w[7:0]}, w0 + 16'(256 >> (2 * m + 1)));
    end
    wrrd("clk_ext", 4'he, 8'h03, 8'h03);
    wr16(4'h0, 16'h0010);
    wr8(4'hf, 8'h0f);
    wr16(4'h2, 16'h0011);
    wr8(4'hf, 8'h1f);
    wr16(4'h2, 16'h0012);
    rd8(4'h3, w);
    chk("cmp_b_lo", w, 16'h0012);
    wr8(4'hf, 8'h0f);
    rd8(4'h3, w);
    chk("cmp_a_lo", w, 16'h0011);
    rd16(4'h0, w);
    chk("cnt_written", w, 16'h0010);
    chk("pins_idle", 16'({oa, ob}), 16'h0000);
    for (int k = 0; k < 3; k++) begin
      pin(4, 1'b1);
      pin(4, 1'b0);
    end
    rd16(4'h0, w);
    chk("cnt_ext", w, 16'h0013);
    chk("pins_match", 16'({oa, ob, compare_out_en_a, compare_out_en_b}), 16'h000f);
    wr8(4'hd, 8'h01);
    wr8(4'hf, 8'h0d);
    wr16(4'h2, 16'h0014);
    for (int k = 0; k < 2; k++) begin
      pin(4, 1'b1);
      pin(4, 1'b0);
    end
    rd16(4'h0, w);
    chk("cnt_cleared", w, 16'h0000);
    chk("pin_a_low", 16'(oa), 16'h0000);
    // capture A on rising edges, then buffered through C
    wrrd("edge_a_rise", 4'he, 8'h83, 8'h83);
    wr16(4'h0, 16'h1234);
    pin(0, 1'b1);
    rd16(4'h4, w);
    chk("cap_a", w, 16'h1234);
    wr8(4'he, 8'h8b);
    wr16(4'h0, 16'h5678);
    pin(0, 1'b0);
    pin(0, 1'b1);
    rd16(4'h4, w);
    chk("cap_a_buf", w, 16'h5678);
    rd16(4'h8, w);
    chk("cap_c_buf", w, 16'h1234);
    pin(2, 1'b1);
    pin(2, 1'b0);
    rd16(4'h8, w);
    chk("cap_c_kept", w, 16'h1234);
    wr8(4'he, 8'h47);
    wr16(4'h0, 16'h0abc);
    pin(1, 1'b1);
    pin(1, 1'b0);
    wr16(4'h0, 16'h0def);
    pin(1, 1'b1);
    rd16(4'ha, w);
    chk("cap_d_buf", w, 16'h0abc);
    rd8(4'hd, w);
    chk("flags_set", w & 16'h00a0, 16'h00a0);
    wr8(4'hc, 8'h80);
    wait_clk(2);
    chk("irq_on", 16'(irq), 16'h0001);
    wr8(4'hd, 8'h01);
    wait_clk(2);
    chk("irq_off", 16'(irq), 16'h0000);
    rd8(4'hd, w);
    chk("flags_clear", w, 16'h0001);
    // low power forces the control registers back
    low_power = 1'b1;
    wait_clk(1);
    rd8(4'he, w);
    chk("cc_low_power", w, 16'h0000);
    rd8(4'hf, w);
    chk("oc_low_power", w, 16'h00e0);
    chk("pins_low_power", 16'({oa, ob, compare_out_en_a, compare_out_en_b}), 16'h0000);
    low_power = 1'b0;
    conclude();
  end
endmodule
